// ==== hw/hcsp_pkg.sv ====
// hcsp_pkg: constants and carrier types of the host control serial port
package hcsp_pkg;
  // timing
  localparam int unsigned CLK_MHZ   = 10;
  localparam int unsigned T1_US     = 2600;
  localparam int unsigned T1_CYC    = T1_US * CLK_MHZ;
  localparam int unsigned GAP_US    = 70;
  localparam int unsigned GAP_CYC   = GAP_US * CLK_MHZ;
  localparam logic [3:0]  MODE_HOLD = 4'h8;

  // link framing
  localparam logic [7:0]  I2C_ADDR_WR = 8'h30;
  localparam logic [7:0]  I2C_ADDR_RD = 8'h31;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [6:0]  Q_BITS      = 7'h60;

  // configuration registers
  localparam logic [63:0] CFG_RESET    = 64'h0000_0000_0000_c000;
  localparam logic [3:0]  REG_STAT_SEL = 4'h2;
  localparam logic [3:0]  REG_MOTOR_E  = 4'he;
  localparam int unsigned STOP6_BIT    = 0;

  // status selections
  localparam logic [3:0]  STAT_SUBQ      = 4'h0;
  localparam logic [3:0]  STAT_SPEED75   = 4'h1;
  localparam logic [3:0]  STAT_SPEED50   = 4'h2;
  localparam logic [3:0]  STAT_STOPPED   = 4'h3;
  localparam logic [3:0]  STAT_LOCK      = 4'h4;
  localparam logic [3:0]  STAT_EXT_A     = 4'h5;
  localparam logic [3:0]  STAT_EXT_B     = 4'h6;
  localparam logic [3:0]  STAT_MOT_SAT   = 4'h7;
  localparam logic [3:0]  STAT_FIFO_OVERFLOW_FLAG   = 4'h8;
  localparam logic [3:0]  STAT_SHOCK     = 4'h9;
  localparam logic [3:0]  STAT_SHOCK_LAT = 4'ha;
  localparam logic [3:0]  STAT_SHOCK_CLR = 4'hb;

  typedef logic [15:0][3:0] hcsp_cfg_t;

  typedef struct packed {
    logic motor_speed_75;
    logic motor_speed_50;
    logic motor_stopped_12;
    logic motor_stopped_6;
    logic sync_lock;
    logic motor_saturation;
    logic fifo_overflow_flag;
    logic servo_int;
    logic off_track_shock;
  } hcsp_stat_t;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_ADDR = 3'h1,
    I2C_ACKA = 3'h3,
    I2C_WR   = 3'h2,
    I2C_ACKW = 3'h6,
    I2C_RD   = 3'h7,
    I2C_ACKR = 3'h5
  } hcsp_i2c_st_t;
endpackage : hcsp_pkg

// ==== hw/hcsp_sync.sv ====
// hcsp_sync: two-flop level synchroniser into the core clock
module hcsp_sync #(
  parameter int unsigned W = 1
) (
  // clock
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else if (ce_i)
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : hcsp_sync

// ==== hw/hcsp_link.sv ====
// hcsp_link: scl-domain shifter, low-phase bit count and gray read index
module hcsp_link (
  // link clock and reset
  input  wire logic       link_scl_i,
  input  wire logic       nrst_i,
  // pins
  input  wire logic       sda_i,
  input  wire logic       register_strobe_i,
  input  wire logic       servo_strobe_i,
  // towards core
  output logic [7:0]      shift_o,
  output logic [3:0]      lo_cnt_o,
  output logic [6:0]      idx_gray_o
);
  logic [6:0] idx_r;
  logic [6:0] idx_nxt;
  logic       idx_clr_n;

  // index only lives inside a read phase; the strobes end it without an scl edge
  assign idx_clr_n = nrst_i & ~(register_strobe_i ^ servo_strobe_i);
  assign idx_nxt   = (idx_r == 7'h7f) ? idx_r : idx_r + 7'h01;

  always_ff @(posedge link_scl_i or negedge nrst_i)
  begin
    if (!nrst_i)
      shift_o <= 8'h00;
    else
      shift_o <= {shift_o[6:0], sda_i};
  end

  always_ff @(posedge link_scl_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lo_cnt_o <= 4'h0;
    else if (register_strobe_i)
      lo_cnt_o <= 4'h0;
    else if (lo_cnt_o != 4'hf)
      lo_cnt_o <= lo_cnt_o + 4'h1;
  end

  // gray so the core may sample the index at any moment
  always_ff @(negedge link_scl_i or negedge idx_clr_n)
  begin
    if (!idx_clr_n)
    begin
      idx_r      <= 7'h00;
      idx_gray_o <= 7'h00;
    end
    else
    begin
      idx_r      <= idx_nxt;
      idx_gray_o <= idx_nxt ^ {1'b0, idx_nxt[6:1]};
    end
  end
endmodule : hcsp_link

// ==== hw/hcsp_top.sv ====
// hcsp_top: host control serial port, 4-wire and I2C slave modes
// Function
// - register high, servo low selects I2C
// - I2C slave answers 30H write, 31H read
// - I2C link runs up to 400 kbit/s
// - I2C mode carries only servo commands
// - address then data, latched on register-strobe rise
// - extra register strobes rewrite same data
// - status read drives selected status bit
// - subcode-ready low when new Q word
// - motor speed and stopped status thresholds
// - lock, pin inputs, overflows as status
// - shock status is OR of flags
// - latched shock status holds once set, until shock-clear is selected
// - direct subcode read, ended by strobe low
// - late read skips next subcode ready
// - bad CRC frame delays next ready
// - write servo bytes taken per servo strobe
// - extra servo strobes repeat last byte
// - read servo command bytes driven out
// - I2C write may concatenate commands
// - I2C read uses read address after command
module hcsp_top #(
  parameter int unsigned T1_CYCLES = hcsp_pkg::T1_CYC
) (
  // clocks and reset
  input  wire logic               core_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  input  wire logic               link_scl_i,
  // host pins
  input  wire logic               register_strobe_i,
  input  wire logic               servo_strobe_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_o,
  // status sources
  input  wire hcsp_pkg::hcsp_stat_t stat_i,
  input  wire logic               ext_input_a_i,
  input  wire logic               ext_input_b_i,
  // subcode frames
  input  wire logic               q_frame_vld_i,
  input  wire logic               q_crc_ok_i,
  input  wire logic [95:0]        q_frame_i,
  output logic                    subcode_ready_n_o,
  // configuration
  output hcsp_pkg::hcsp_cfg_t     cfg_o,
  output logic                    status_bit_o,
  output logic                    i2c_mode_o,
  // servo command stream
  output logic [7:0]              servo_byte_o,
  output logic                    servo_byte_vld_o,
  input  wire logic               servo_rd_active_i,
  input  wire logic [7:0]         servo_rd_byte_i,
  output logic                    servo_rd_take_o,
  output logic                    servo_gap_err_o
);
  localparam logic [14:0] T1_LIM  = T1_CYCLES[14:0];
  localparam logic [9:0]  GAP_LIM = hcsp_pkg::GAP_CYC[9:0];

  function automatic logic [6:0] gray2bin(input logic [6:0] g);
    logic [6:0] b;
    b[6] = g[6];
    for (int i = 5; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : gray2bin

  logic [5:0]  pin_s;
  logic        rstb_s, sstb_s, scl_s, sda_s, ext_a_s, ext_b_s;
  logic [3:0]  pin_d_r;
  logic [7:0]  sr_l;
  logic [3:0]  lo_l;
  logic [6:0]  idxg_l;
  logic [18:0] link_s;
  logic [7:0]  sr_s;
  logic [3:0]  lo_s;
  logic [6:0]  idx_s;
  logic        rstb_rise, rstb_fall, sstb_rise, sstb_fall;
  logic        scl_rise, scl_fall, i2c_start, i2c_stop;

  hcsp_link u_link (
    .link_scl_i        (link_scl_i),
    .nrst_i            (nrst_i),
    .sda_i             (sda_i),
    .register_strobe_i (register_strobe_i),
    .servo_strobe_i    (servo_strobe_i),
    .shift_o           (sr_l),
    .lo_cnt_o          (lo_l),
    .idx_gray_o        (idxg_l)
  );

  hcsp_sync #(.W(6)) u_pin_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .d_i        ({register_strobe_i, servo_strobe_i, link_scl_i, sda_i, ext_input_a_i, ext_input_b_i}),
    .q_o        (pin_s)
  );

  // shift and count are quiet while scl is held, so their 2-flop copy is coherent at a strobe
  hcsp_sync #(.W(19)) u_link_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .d_i        ({sr_l, lo_l, idxg_l}),
    .q_o        (link_s)
  );

  assign {rstb_s, sstb_s, scl_s, sda_s, ext_a_s, ext_b_s} = pin_s;
  assign sr_s      = link_s[18:11];
  assign lo_s      = link_s[10:7];
  assign idx_s     = gray2bin(link_s[6:0]);
  assign rstb_rise = rstb_s & ~pin_d_r[3];
  assign rstb_fall = ~rstb_s & pin_d_r[3];
  assign sstb_rise = sstb_s & ~pin_d_r[2];
  assign sstb_fall = ~sstb_s & pin_d_r[2];
  assign scl_rise  = scl_s & ~pin_d_r[1];
  assign scl_fall  = ~scl_s & pin_d_r[1];
  assign i2c_start = scl_s & pin_d_r[1] & pin_d_r[0] & ~sda_s;
  assign i2c_stop  = scl_s & pin_d_r[1] & ~pin_d_r[0] & sda_s;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pin_d_r <= 4'hf;
    else if (ce_i)
      pin_d_r <= {rstb_s, sstb_s, scl_s, sda_s};
  end

  // mode: held combination, filtered so 4-wire strobe edges never flip it
  logic [3:0] mode_cnt_r;
  logic       i2c_mode_r;
  logic       i2c_pins;

  assign i2c_pins = rstb_s & ~sstb_s;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_cnt_r <= 4'h0;
      i2c_mode_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!i2c_pins)
      begin
        mode_cnt_r <= 4'h0;
        i2c_mode_r <= 1'b0;
      end
      else if (mode_cnt_r != hcsp_pkg::MODE_HOLD)
      begin
        mode_cnt_r <= mode_cnt_r + 4'h1;
        i2c_mode_r <= i2c_mode_r | (mode_cnt_r == hcsp_pkg::MODE_HOLD - 4'h1);
      end
    end
  end

  // configuration registers
  hcsp_pkg::hcsp_cfg_t cfg_r;
  logic [3:0]          sel;
  logic                wr_ok;

  assign sel   = cfg_r[hcsp_pkg::REG_STAT_SEL];
  // lo_s stays at eight or more (saturating at 15) after a write, so repeat pulses write again
  assign wr_ok = ce_i & ~i2c_mode_r & rstb_rise & sstb_s & (lo_s >= hcsp_pkg::BYTE_BITS);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cfg_r <= hcsp_pkg::CFG_RESET;
    else if (wr_ok)
      cfg_r[sr_s[7:4]] <= sr_s[3:0];
  end

  // status selection
  logic shock_w;
  logic shock_lat_r;
  logic stat_bit;
  logic ready_n_r;

  assign shock_w = stat_i.motor_speed_50 | stat_i.sync_lock | stat_i.motor_saturation
                 | stat_i.fifo_overflow_flag | stat_i.servo_int | stat_i.off_track_shock;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      shock_lat_r <= 1'b0;
    else if (ce_i)
      shock_lat_r <= shock_w | (shock_lat_r & (sel != hcsp_pkg::STAT_SHOCK_CLR));
  end

  always_comb
  begin
    case (sel)
      hcsp_pkg::STAT_SUBQ:      stat_bit = ready_n_r;
      hcsp_pkg::STAT_SPEED75:   stat_bit = stat_i.motor_speed_75;
      hcsp_pkg::STAT_SPEED50:   stat_bit = stat_i.motor_speed_50;
      hcsp_pkg::STAT_STOPPED:   stat_bit = cfg_r[hcsp_pkg::REG_MOTOR_E][hcsp_pkg::STOP6_BIT]
                                         ? stat_i.motor_stopped_6 : stat_i.motor_stopped_12;
      hcsp_pkg::STAT_LOCK:      stat_bit = stat_i.sync_lock;
      hcsp_pkg::STAT_EXT_A:     stat_bit = ext_a_s;
      hcsp_pkg::STAT_EXT_B:     stat_bit = ext_b_s;
      hcsp_pkg::STAT_MOT_SAT:   stat_bit = stat_i.motor_saturation;
      hcsp_pkg::STAT_FIFO_OVERFLOW_FLAG:   stat_bit = stat_i.fifo_overflow_flag;
      hcsp_pkg::STAT_SHOCK:     stat_bit = shock_w;
      hcsp_pkg::STAT_SHOCK_LAT: stat_bit = shock_lat_r;
      hcsp_pkg::STAT_SHOCK_CLR: stat_bit = shock_lat_r;
      default:                  stat_bit = 1'b0;
    endcase
  end

  // subcode ready and Q word
  logic [95:0] q_r;
  logic [14:0] t1_cnt_r;
  logic        reading_r, skip_r, rd_end, good_frame, q_load, t1_hit;

  assign good_frame = q_frame_vld_i & q_crc_ok_i;
  assign q_load     = good_frame & ~reading_r & ~skip_r;
  assign rd_end     = reading_r & rstb_fall;
  assign t1_hit     = (t1_cnt_r == T1_LIM);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reading_r <= 1'b0;
    else if (ce_i)
    begin
      if (rstb_fall || i2c_mode_r)
        reading_r <= 1'b0;
      else if (!i2c_mode_r && rstb_s && sstb_s && sel == hcsp_pkg::STAT_SUBQ && idx_s != 7'h00)
        reading_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      t1_cnt_r <= 15'h0000;
    else if (ce_i)
    begin
      if (q_load)
        t1_cnt_r <= 15'h0000;
      else if (!ready_n_r && !t1_hit)
        t1_cnt_r <= t1_cnt_r + 15'h0001;
    end
  end

  // q_r only moves outside a read, so the link sees a still word
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q_r       <= '0;
      ready_n_r <= 1'b1;
      skip_r    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (q_load)
      begin
        q_r       <= q_frame_i;
        ready_n_r <= 1'b0;
      end
      if (rd_end)
      begin
        ready_n_r <= 1'b1;
        skip_r    <= t1_hit;
      end
      else if (good_frame && !reading_r && skip_r)
        skip_r    <= 1'b0;
    end
  end

  // I2C slave; scl is oversampled 25 times per bit at 400 kbit/s
  hcsp_pkg::hcsp_i2c_st_t st_r;
  logic [7:0] sh_r, tx_r;
  logic [3:0] bcnt_r;
  logic       dir_rd_r, nack_r, i2c_wr_evt, i2c_rd_evt, i2c_oe;

  assign i2c_wr_evt = (st_r == hcsp_pkg::I2C_WR) & scl_fall & (bcnt_r == hcsp_pkg::BYTE_BITS);
  assign i2c_rd_evt = scl_fall & (((st_r == hcsp_pkg::I2C_ACKA) & dir_rd_r)
                    | ((st_r == hcsp_pkg::I2C_ACKR) & ~nack_r));

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r     <= hcsp_pkg::I2C_IDLE;
      sh_r     <= 8'h00;
      tx_r     <= 8'hff;
      bcnt_r   <= 4'h0;
      dir_rd_r <= 1'b0;
      nack_r   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!i2c_mode_r || i2c_stop)
        st_r <= hcsp_pkg::I2C_IDLE;
      else if (i2c_start)
      begin
        st_r   <= hcsp_pkg::I2C_ADDR;
        bcnt_r <= 4'h0;
      end
      else
        case (st_r)
          hcsp_pkg::I2C_ADDR, hcsp_pkg::I2C_WR:
          begin
            if (scl_rise)
            begin
              sh_r   <= {sh_r[6:0], sda_s};
              bcnt_r <= bcnt_r + 4'h1;
            end
            else if (scl_fall && bcnt_r == hcsp_pkg::BYTE_BITS)
            begin
              bcnt_r <= 4'h0;
              if (st_r == hcsp_pkg::I2C_WR)
                st_r <= hcsp_pkg::I2C_ACKW;
              else if (sh_r == hcsp_pkg::I2C_ADDR_WR || sh_r == hcsp_pkg::I2C_ADDR_RD)
              begin
                st_r     <= hcsp_pkg::I2C_ACKA;
                dir_rd_r <= (sh_r == hcsp_pkg::I2C_ADDR_RD);
              end
              else
                st_r <= hcsp_pkg::I2C_IDLE;
            end
          end
          hcsp_pkg::I2C_ACKA, hcsp_pkg::I2C_ACKW:
            if (scl_fall)
              st_r <= (dir_rd_r && st_r == hcsp_pkg::I2C_ACKA) ? hcsp_pkg::I2C_RD : hcsp_pkg::I2C_WR;
          hcsp_pkg::I2C_RD:
            if (scl_fall)
            begin
              bcnt_r <= bcnt_r + 4'h1;
              if (bcnt_r == hcsp_pkg::BYTE_BITS - 4'h1)
              begin
                bcnt_r <= 4'h0;
                st_r   <= hcsp_pkg::I2C_ACKR;
              end
            end
          hcsp_pkg::I2C_ACKR:
            if (scl_rise)
              nack_r <= sda_s;
            else if (scl_fall)
              st_r <= nack_r ? hcsp_pkg::I2C_IDLE : hcsp_pkg::I2C_RD;
          default:
            st_r <= hcsp_pkg::I2C_IDLE;
        endcase
      if (i2c_rd_evt)
        tx_r <= servo_rd_byte_i;
      else if (st_r == hcsp_pkg::I2C_RD && scl_fall)
        tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  // open drain: enable only pulls low
  assign i2c_oe = (st_r == hcsp_pkg::I2C_ACKA) | (st_r == hcsp_pkg::I2C_ACKW)
                | ((st_r == hcsp_pkg::I2C_RD) & ~tx_r[7]);

  // servo command stream from either mode
  logic srv_evt;
  assign srv_evt = ce_i & ~i2c_mode_r & sstb_rise & ~rstb_s;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      servo_byte_o     <= 8'h00;
      servo_byte_vld_o <= 1'b0;
      servo_rd_take_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      servo_byte_vld_o <= i2c_wr_evt | (srv_evt & ~servo_rd_active_i);
      servo_rd_take_o  <= i2c_rd_evt | (srv_evt & servo_rd_active_i);
      if (i2c_wr_evt)
        servo_byte_o <= sh_r;
      else if (srv_evt && !servo_rd_active_i)
        servo_byte_o <= sr_s;
    end
  end

  // strobe spacing watch, from strobe end to next strobe start
  logic [9:0] gap_cnt_r;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gap_cnt_r       <= GAP_LIM;
      servo_gap_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      servo_gap_err_o <= ~i2c_mode_r & sstb_fall & (gap_cnt_r != GAP_LIM);
      if (!i2c_mode_r && sstb_rise)
        gap_cnt_r <= 10'h000;
      else if (gap_cnt_r != GAP_LIM)
        gap_cnt_r <= gap_cnt_r + 10'h001;
    end
  end

  // 4-wire read drive; bits follow scl falls with three core cycles of lag
  logic stat_ph, srv_ph, fw_bit;

  assign stat_ph = ~i2c_mode_r & rstb_s & sstb_s;
  assign srv_ph  = ~i2c_mode_r & ~rstb_s & ~sstb_s & servo_rd_active_i;

  always_comb
  begin
    fw_bit = stat_bit;
    if (srv_ph)
      fw_bit = (idx_s < 7'h08) ? servo_rd_byte_i[3'h7 - idx_s[2:0]] : 1'b1;
    else if (sel == hcsp_pkg::STAT_SUBQ && idx_s != 7'h00)
      fw_bit = (idx_s <= hcsp_pkg::Q_BITS) ? q_r[hcsp_pkg::Q_BITS - idx_s] : 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sda_o    <= 1'b1;
      sda_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sda_oe_o <= i2c_mode_r ? i2c_oe : (stat_ph | srv_ph);
      sda_o    <= i2c_mode_r ? 1'b0 : fw_bit;
    end
  end

  assign cfg_o             = cfg_r;
  assign status_bit_o      = stat_bit;
  assign i2c_mode_o        = i2c_mode_r;
  assign subcode_ready_n_o = ready_n_r;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_mode_exit: assert property (ce_i && !i2c_pins |=> !i2c_mode_o)
    else $error("mode kept without pin combination");
  a_mode_enter: assert property ((ce_i && i2c_pins) [*8] |=> i2c_mode_o)
    else $error("I2C mode not entered after hold");
  a_cfg_latch: assert property (wr_ok ##1 ce_i |-> cfg_o[$past(sr_s[7:4])] == $past(sr_s[3:0]))
    else $error("register write not latched");
  a_addr_ack: assert property (ce_i && i2c_mode_r && st_r == hcsp_pkg::I2C_ADDR && scl_fall
                               && bcnt_r == 4'h8 && sh_r == 8'h30 ##1 ce_i |=> sda_oe_o)
    else $error("write address not acknowledged");
  a_stat_drive: assert property (ce_i && stat_ph && sel != 4'h0 |=> sda_oe_o && sda_o == $past(stat_bit))
    else $error("status bit not driven");
  a_host_free: assert property (ce_i && !i2c_mode_r && !rstb_s && sstb_s |=> !sda_oe_o)
    else $error("data driven while host owns line");
  a_shock_hold: assert property (ce_i && shock_lat_r && sel != 4'hb |=> shock_lat_r)
    else $error("latched shock lost");
  a_shock_set: assert property (ce_i && stat_i.servo_int |=> shock_lat_r)
    else $error("shock source not latched");
  a_subq_load: assert property (ce_i && q_load |=> !subcode_ready_n_o && q_r == $past(q_frame_i))
    else $error("new subcode not flagged");
  a_crc_drop: assert property (ce_i && q_frame_vld_i && !q_crc_ok_i |=> $stable(q_r))
    else $error("bad frame loaded");
  a_late_skip: assert property (ce_i && rd_end && t1_hit |=> skip_r && subcode_ready_n_o)
    else $error("late read did not skip frame");
  a_servo_byte: assert property (srv_evt && !servo_rd_active_i |=> servo_byte_vld_o
                                 && servo_byte_o == $past(sr_s))
    else $error("servo byte not issued");

  c_cfg_write: cover property (wr_ok);
  c_subq_read: cover property (rd_end);
  c_i2c_write: cover property (i2c_wr_evt);
  c_i2c_read: cover property (i2c_rd_evt);
endmodule : hcsp_top

// ==== verif/hcsp_host_model.sv ====
// hcsp_host_model: host controller model on the serial pins
module hcsp_host_model (
  // pins
  output logic scl_o,
  output logic sda_o,
  output logic register_strobe_o,
  output logic servo_strobe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    register_strobe_o = 1'b0;
    servo_strobe_o = 1'b1;
  end
  // msb first; clock left high so repeat strobes stay legal
  task automatic send(input logic [7:0] b, input int half);
    for (int i = 7; i >= 0; i--)
    begin
      scl_o = 1'b0;
      sda_o = b[i];
      #half scl_o = 1'b1;
      #half;
    end
  endtask : send
  task automatic strobe_reg(input logic v);
    register_strobe_o = v;
  endtask : strobe_reg
  task automatic servo(input logic [7:0] b);
    servo_strobe_o = 1'b0;
    send(b, 16);
    servo_strobe_o = 1'b1;
  endtask : servo
  task automatic pulse_servo();
    servo_strobe_o = 1'b0;
    #200 servo_strobe_o = 1'b1;
  endtask : pulse_servo
  // 2.5 us bit period; released data line goes to the pull-up level
  task automatic i2c_addr(input logic [7:0] b);
    register_strobe_o = 1'b1;
    servo_strobe_o = 1'b0;
    #2000 sda_o = 1'b0;
    #1250 send(b, 1250);
    scl_o = 1'b0;
    sda_o = 1'b1;
  endtask : i2c_addr
endmodule : hcsp_host_model

// ==== verif/host_control_serial_port_tb_top.sv ====
// host_control_serial_port_tb_top: directed bench for the serial port
module host_control_serial_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 core_clk_i = 1'b0;
  logic                 nrst_i     = 1'b0;
  logic                 ext_a      = 1'b0;
  logic                 ext_b      = 1'b0;
  logic                 q_vld      = 1'b0;
  logic                 q_ok       = 1'b0;
  logic [95:0]          q_frame    = {8'h01, 88'h0};
  hcsp_pkg::hcsp_stat_t stat       = '0;
  hcsp_pkg::hcsp_cfg_t  cfg;
  logic                 scl, hsda, rstb, sstb, sda, sda_oe, rdy_n, i2c, vld, sda_w;
  logic [7:0]           sbyte;
  logic                 ce         = 1'b1;
  logic                 rd_act     = 1'b0;
  logic [7:0]           rd_byte    = 8'h00;
  logic                 status_bit, rd_take, gap_err;
  logic [10:0]          pat [1:10] = '{11'h100, 11'h080, 11'h020, 11'h010, 11'h200, 11'h400, 11'h008, 11'h004,
                                       11'h001, 11'h000};
  int                   err_total  = 0;
  int                   n_compared = 0;
  always #50 core_clk_i = ~core_clk_i;
  assign sda_w = sda_oe ? sda : hsda;
  hcsp_top #(.T1_CYCLES(50)) dut (
    .core_clk_i, .nrst_i, .ce_i(ce), .link_scl_i(scl), .register_strobe_i(rstb), .servo_strobe_i(sstb),
    .sda_i(sda_w), .sda_o(sda), .sda_oe_o(sda_oe), .stat_i(stat), .ext_input_a_i(ext_a), .ext_input_b_i(ext_b),
    .q_frame_vld_i(q_vld), .q_crc_ok_i(q_ok), .q_frame_i(q_frame), .subcode_ready_n_o(rdy_n), .cfg_o(cfg),
    .status_bit_o(status_bit), .i2c_mode_o(i2c), .servo_byte_o(sbyte), .servo_byte_vld_o(vld),
    .servo_rd_active_i(rd_act), .servo_rd_byte_i(rd_byte), .servo_rd_take_o(rd_take), .servo_gap_err_o(gap_err));
  hcsp_host_model host (.scl_o(scl), .sda_o(hsda), .register_strobe_o(rstb), .servo_strobe_o(sstb));
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic ticks(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : ticks
  task automatic catch_byte(input logic [7:0] exp);
    int i;
    for (i = 0; i < 20 && vld !== 1'b1; i++)
      @(negedge core_clk_i);
    cmp(sbyte, exp);
    if (i == 20)
    begin
      err_total++;
      conclude();
    end
  endtask : catch_byte
  // the write strobe also opens a status read, so both are checked
  task automatic reg_acc(input logic [3:0] a, input logic [3:0] d, input logic st);
    host.send({a, d}, 16);
    cmp(sda_oe, 1'b0);
    host.strobe_reg(1'b1);
    ticks(8);
    cmp(cfg[a], d);
    cmp(sda_oe, 1'b1);
    if (a == 4'h2) cmp(sda_w, st);
    if (a == 4'h2) cmp(status_bit, st);
    host.strobe_reg(1'b0);
    ticks(8);
  endtask : reg_acc
  task automatic frame(input logic ok, input logic exp);
    @(posedge core_clk_i);
    q_vld <= 1'b1;
    q_ok <= ok;
    @(posedge core_clk_i);
    q_vld <= 1'b0;
    ticks(4);
    cmp(rdy_n, exp);
  endtask : frame
  initial
  begin
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    ticks(4);
    cmp({cfg, rdy_n, sda_oe, i2c}, {hcsp_pkg::CFG_RESET, 3'b100});
    $display("reset values done");
    // never zero, and register 3 differs from its reset value
    for (int a = 0; a < 16; a++)
      reg_acc(a[3:0], a[3:0] | 4'h1, 1'b0);
    $display("register writes done");
    for (int s = 1; s <= 10; s++)
    begin
      @(posedge core_clk_i);
      {ext_b, ext_a, stat} <= pat[s];
      reg_acc(4'h2, s[3:0], 1'b1);
    end
    @(posedge core_clk_i);
    stat <= '0;
    $display("status selections done");
    reg_acc(4'h2, 4'h0, 1'b1);
    frame(1'b0, 1'b1);
    frame(1'b1, 1'b0);
    host.strobe_reg(1'b1);
    ticks(8);
    cmp(sda_w, 1'b0);
    host.send(8'h00, 1000);
    ticks(8);
    cmp(sda_w, 1'b1);
    host.strobe_reg(1'b0);
    ticks(8);
    cmp(rdy_n, 1'b1);
    frame(1'b1, 1'b1);
    frame(1'b1, 1'b0);
    $display("subcode done");
    host.servo(8'ha5);
    catch_byte(8'ha5);
    ticks(800);
    host.pulse_servo();
    catch_byte(8'ha5);
    ticks(800);
    cmp({gap_err, rd_take}, 2'b00);
    $display("servo bytes done");
    host.i2c_addr(hcsp_pkg::I2C_ADDR_WR);
    cmp(i2c, 1'b1);
    ticks(8);
    cmp({sda_oe, sda}, 2'b10);
    $display("slave mode done");
    conclude();
  end
  initial
  begin
    #5000000;
    err_total++;
    conclude();
  end
endmodule : host_control_serial_port_tb_top
